// >>> logic/dspm_pkg.sv
// Package with offsets, fields, reset values and op codes of the MAC datapath
package dspm_pkg;

  // Datapath widths
  localparam int ACC_W  = 40;
  localparam int OPD_W  = 16;
  localparam int MUL_W  = 17;
  localparam int PROD_W = 33;
  localparam int DATA_W = 32;

  // APB register byte offsets
  localparam logic [11:0] OFF_CORE = 12'h000;
  localparam logic [11:0] OFF_TRAP = 12'h004;
  localparam logic [11:0] OFF_OPA  = 12'h008;
  localparam logic [11:0] OFF_OPB  = 12'h00C;
  localparam logic [11:0] OFF_DATA = 12'h010;
  localparam logic [11:0] OFF_CMD  = 12'h014;
  localparam logic [11:0] OFF_STAT = 12'h018;
  localparam logic [11:0] OFF_PROD = 12'h01C;
  localparam logic [11:0] OFF_A1L  = 12'h020;
  localparam logic [11:0] OFF_A1H  = 12'h024;
  localparam logic [11:0] OFF_A2L  = 12'h028;
  localparam logic [11:0] OFF_A2H  = 12'h02C;

  // core_control_reg fields
  localparam int CORE_FRAC_BIT  = 0;
  localparam int CORE_SGNA_BIT  = 1;
  localparam int CORE_SGNB_BIT  = 2;
  localparam int CORE_WIDTH_BIT = 4;
  localparam int CORE_CL2_BIT   = 6;
  localparam int CORE_CL1_BIT   = 7;
  localparam logic [7:0] CORE_RST = 8'h07;

  // trap_control_reg fields
  localparam int TRAP_EN1_BIT  = 0;
  localparam int TRAP_EN2_BIT  = 1;
  localparam int TRAP_FLAG_BIT = 8;

  // Command register fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_SEL_BIT   = 4;
  localparam int CMD_BYTE_BIT  = 5;
  localparam int CMD_ZERO_BIT  = 6;
  localparam int CMD_CIN_BIT   = 7;
  localparam int CMD_SHIFT_LSB = 8;
  localparam int SHIFT_W       = 5;
  localparam logic [15:0] CMD_RST = 16'h0000;

  // Status register fields
  localparam int ST_GOV1_BIT = 0;
  localparam int ST_GOV2_BIT = 1;
  localparam int ST_GANY_BIT = 2;
  localparam int ST_CL1_BIT  = 3;
  localparam int ST_CL2_BIT  = 4;
  localparam int ST_CANY_BIT = 5;
  localparam int ST_SL1_BIT  = 6;
  localparam int ST_SL2_BIT  = 7;

  // Saturation limits
  localparam logic [39:0] SAT31_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT31_NEG = 40'hFF_8000_0000;
  localparam logic [39:0] SAT39_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT39_NEG = 40'h80_0000_0000;
  localparam logic [39:0] ACC_RST   = 40'h00_0000_0000;

  // Operations issued through the command register
  typedef enum logic [2:0] {
    OP_MAC,
    OP_MSC,
    OP_ADD,
    OP_SUB,
    OP_LOAD,
    OP_PRODUCT
  } dspm_op_e;

endpackage : dspm_pkg

// >>> logic/dspm_mult.sv
// Module with the 17x17 multiplier and fractional or integer scaler
`timescale 1ns/100ps
module dspm_mult (
  input  wire logic [dspm_pkg::OPD_W-1:0]  op_a,
  input  wire logic [dspm_pkg::OPD_W-1:0]  op_b,
  input  wire logic                        a_signed,
  input  wire logic                        b_signed,
  input  wire logic                        frac_mode,
  output logic      [dspm_pkg::PROD_W-1:0] product
);
  import dspm_pkg::*;

  logic [MUL_W-1:0] ext_a;
  logic [MUL_W-1:0] ext_b;
  logic signed [PROD_W:0] raw;

  // Seventeenth bit: copy of sign when signed, zero when unsigned
  assign ext_a = {a_signed & op_a[OPD_W-1], op_a};
  assign ext_b = {b_signed & op_b[OPD_W-1], op_b};

  // Mixed sign works because each side carries its own extension
  assign raw = $signed(ext_a) * $signed(ext_b);

  // Fractional mode drops the redundant sign bit to align 1.31
  always_comb begin
    if (frac_mode) begin
      product = {raw[PROD_W-2:0], 1'b0};
    end else begin
      product = raw[PROD_W-1:0];
    end
  end

endmodule : dspm_mult

// >>> logic/dspm_mac.sv
// Top module: APB register file, accumulators, adder, saturation and status
//
// Notes on behaviour
// - Unsigned operands get zero seventeenth bit
// - Signed operands copy sign into seventeenth bit
// - 33-bit product sign-extended to forty bits
// - Scaler picks 1.31 or 32-bit integer alignment
// - Fractions: binary point right after sign
// - Fractional 16x16 multiply yields 1.31 product
// - Multiplier serves signed, unsigned, mixed integers
// - Product: bytes give 16 bits, words 32
// - Selected accumulator is both source and destination
// - Add and load data optionally barrel shifted
// - One adder input zeroable, other true/inverted
// - Add: carry high; subtract: borrow low, inverted
// - Detect overflow out of bit 39
// - Guard overflow when bits 32-39 differ
// - Saturation uses result, flags, enables, width
// - Clamped flag sets when accumulator saturates
// - Summary flags are OR of both
// - Guard flag reflects latest adder operation only
// - Enabled guard overflow raises arithmetic trap
`timescale 1ns/100ps
module dspm_mac (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             arith_trap,
  output logic             acc_one_guard_ovf,
  output logic             acc_two_guard_ovf,
  output logic             any_guard_ovf,
  output logic             acc_one_clamped,
  output logic             acc_two_clamped,
  output logic             any_clamped
);
  import dspm_pkg::*;

  // Software visible state
  logic [7:0]        core_r;
  logic              trap_en_one_r;
  logic              trap_en_two_r;
  logic              trap_flag_r;
  logic [OPD_W-1:0]  opa_r;
  logic [OPD_W-1:0]  opb_r;
  logic [DATA_W-1:0] data_r;
  logic [15:0]       cmd_r;
  logic              go_r;
  logic [DATA_W-1:0] prod_r;
  logic [ACC_W-1:0]  acc_one_r;
  logic [ACC_W-1:0]  acc_two_r;
  logic              gov_one_r;
  logic              gov_two_r;
  logic              clamp_one_r;
  logic              clamp_two_r;
  logic              lost_one_r;
  logic              lost_two_r;
  logic              trap_r;
  logic [31:0]       prdata_r;

  // Bus decode
  logic        wr_en;
  logic        rd_setup;
  logic        hit;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  // Datapath wires
  dspm_op_e            op;
  logic                sel_two;
  logic                byte_mode;
  logic                acc_op;
  logic                sub_op;
  logic [OPD_W-1:0]    mul_a;
  logic [OPD_W-1:0]    mul_b;
  logic                mul_frac;
  logic [PROD_W-1:0]   mprod;
  logic [ACC_W-1:0]    prod40;
  logic [ACC_W-1:0]    data40;
  logic [ACC_W-1:0]    shifted;
  logic [SHIFT_W-1:0]  shamt;
  logic [SHIFT_W-1:0]  shneg;
  logic [ACC_W-1:0]    src;
  logic [ACC_W-1:0]    acc_in;
  logic [ACC_W-1:0]    in_a;
  logic [ACC_W-1:0]    in_b;
  logic [ACC_W:0]      sum;
  logic [ACC_W-1:0]    res;
  logic                ovf39;
  logic                ovf31;
  logic                guard;
  logic                clamp_en;
  logic                wide_sat;
  logic                sat_hit;
  logic                neg_true;
  logic [ACC_W-1:0]    sat_val;
  logic [ACC_W-1:0]    acc_nxt;
  logic                exec;
  logic                trap_hit;

  // Zero wait states; every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_r;

  // Command fields
  assign op        = dspm_op_e'(cmd_r[CMD_OP_LSB +: 3]);
  assign sel_two   = cmd_r[CMD_SEL_BIT];
  assign byte_mode = cmd_r[CMD_BYTE_BIT];
  assign shamt     = cmd_r[CMD_SHIFT_LSB +: SHIFT_W];
  assign shneg     = SHIFT_W'(~shamt + 1'b1);
  assign acc_op    = (op == OP_MAC) || (op == OP_MSC) || (op == OP_ADD)
                   || (op == OP_SUB) || (op == OP_LOAD);
  assign sub_op    = (op == OP_MSC) || (op == OP_SUB);
  assign exec      = go_r & acc_op;

  // Operand preparation; byte mode narrows both sides for the product op
  always_comb begin
    mul_a    = opa_r;
    mul_b    = opb_r;
    mul_frac = core_r[CORE_FRAC_BIT];
    if (op == OP_PRODUCT) begin
      mul_frac = 1'b0;
      if (byte_mode) begin
        mul_a = {{8{core_r[CORE_SGNA_BIT] & opa_r[7]}}, opa_r[7:0]};
        mul_b = {{8{core_r[CORE_SGNB_BIT] & opb_r[7]}}, opb_r[7:0]};
      end
    end
  end

  dspm_mult u_mult (
    .op_a      (mul_a),
    .op_b      (mul_b),
    .a_signed  (core_r[CORE_SGNA_BIT]),
    .b_signed  (core_r[CORE_SGNB_BIT]),
    .frac_mode (mul_frac),
    .product   (mprod)
  );

  // Product joins the accumulator path at full width
  assign prod40 = {{(ACC_W-PROD_W){mprod[PROD_W-1]}}, mprod};
  assign data40 = {{(ACC_W-DATA_W){data_r[DATA_W-1]}}, data_r};

  // Barrel shifter: positive amount shifts right, negative shifts left
  always_comb begin
    if (shamt[SHIFT_W-1]) begin
      shifted = data40 << shneg;
    end else begin
      shifted = $unsigned($signed(data40) >>> shamt);
    end
  end

  // Adder inputs: zeroable accumulator side, true or complemented data side
  always_comb begin
    src    = (op == OP_MAC || op == OP_MSC) ? prod40 : shifted;
    acc_in = sel_two ? acc_two_r : acc_one_r;
    if (cmd_r[CMD_ZERO_BIT] || op == OP_LOAD) begin
      in_a = '0;
    end else begin
      in_a = acc_in;
    end
    if (sub_op) begin
      in_b = ~src;
    end else begin
      in_b = src;
    end
  end

  // Carry input: carry on add, active-low borrow on subtract
  assign sum = {1'b0, in_a} + {1'b0, in_b} + {{ACC_W{1'b0}}, cmd_r[CMD_CIN_BIT]};
  assign res = sum[ACC_W-1:0];

  // Overflow detection
  assign ovf39 = (in_a[39] == in_b[39]) && (res[39] != in_a[39]);
  assign guard = ~((&res[39:32]) | ~(|res[39:32]));
  assign ovf31 = ~((&res[39:31]) | ~(|res[39:31]));

  // Saturation decision; sign after a bit-39 wrap is the inverse of bit 39
  always_comb begin
    clamp_en = sel_two ? core_r[CORE_CL2_BIT] : core_r[CORE_CL1_BIT];
    wide_sat = core_r[CORE_WIDTH_BIT];
    neg_true = ovf39 ? ~res[39] : res[39];
    if (wide_sat) begin
      sat_hit = clamp_en & ovf39;
      sat_val = neg_true ? SAT39_NEG : SAT39_POS;
    end else begin
      sat_hit = clamp_en & (ovf31 | ovf39);
      sat_val = neg_true ? SAT31_NEG : SAT31_POS;
    end
    acc_nxt = sat_hit ? sat_val : res;
  end

  // Trap when the selected accumulator's guard overflow is enabled
  assign trap_hit = exec & guard & (sel_two ? trap_en_two_r : trap_en_one_r);

  // Address decode
  always_comb begin
    hit = 1'b1;
    if (paddr == OFF_CORE) begin
      rd_mux = {24'h00_0000, core_r};
    end else if (paddr == OFF_TRAP) begin
      rd_mux = {23'h00_0000, trap_flag_r, 6'h00, trap_en_two_r, trap_en_one_r};
    end else if (paddr == OFF_OPA) begin
      rd_mux = {16'h0000, opa_r};
    end else if (paddr == OFF_OPB) begin
      rd_mux = {16'h0000, opb_r};
    end else if (paddr == OFF_DATA) begin
      rd_mux = data_r;
    end else if (paddr == OFF_CMD) begin
      rd_mux = {16'h0000, cmd_r};
    end else if (paddr == OFF_STAT) begin
      rd_mux = stat_word;
    end else if (paddr == OFF_PROD) begin
      rd_mux = prod_r;
    end else if (paddr == OFF_A1L) begin
      rd_mux = acc_one_r[31:0];
    end else if (paddr == OFF_A1H) begin
      rd_mux = {24'h00_0000, acc_one_r[39:32]};
    end else if (paddr == OFF_A2L) begin
      rd_mux = acc_two_r[31:0];
    end else if (paddr == OFF_A2H) begin
      rd_mux = {24'h00_0000, acc_two_r[39:32]};
    end else begin
      hit    = 1'b0;
      rd_mux = 32'h0000_0000;
    end
  end

  // Status word as software sees it
  always_comb begin
    stat_word              = 32'h0000_0000;
    stat_word[ST_GOV1_BIT] = gov_one_r;
    stat_word[ST_GOV2_BIT] = gov_two_r;
    stat_word[ST_GANY_BIT] = any_guard_ovf;
    stat_word[ST_CL1_BIT]  = clamp_one_r;
    stat_word[ST_CL2_BIT]  = clamp_two_r;
    stat_word[ST_CANY_BIT] = any_clamped;
    stat_word[ST_SL1_BIT]  = lost_one_r;
    stat_word[ST_SL2_BIT]  = lost_two_r;
  end

  // Read data captured in the setup cycle so it stands through access
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  // Control and operand registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      core_r        <= CORE_RST;
      trap_en_one_r <= 1'b0;
      trap_en_two_r <= 1'b0;
      opa_r         <= 16'h0000;
      opb_r         <= 16'h0000;
      data_r        <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr == OFF_CORE) begin
        core_r <= pwdata[7:0];
      end else if (paddr == OFF_TRAP) begin
        trap_en_one_r <= pwdata[TRAP_EN1_BIT];
        trap_en_two_r <= pwdata[TRAP_EN2_BIT];
      end else if (paddr == OFF_OPA) begin
        opa_r <= pwdata[15:0];
      end else if (paddr == OFF_OPB) begin
        opb_r <= pwdata[15:0];
      end else if (paddr == OFF_DATA) begin
        data_r <= pwdata;
      end
    end
  end

  // Command capture; the operation runs on the following edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_r <= CMD_RST;
      go_r  <= 1'b0;
    end else begin
      go_r <= wr_en && (paddr == OFF_CMD);
      if (wr_en && (paddr == OFF_CMD)) begin
        cmd_r <= pwdata[15:0];
      end
    end
  end

  // Product result register, written only by the product operation
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prod_r <= 32'h0000_0000;
    end else if (go_r && op == OP_PRODUCT) begin
      if (byte_mode) begin
        prod_r <= {16'h0000, mprod[15:0]};
      end else begin
        prod_r <= mprod[31:0];
      end
    end
  end

  // Accumulators; only the selected one takes the result
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_one_r <= ACC_RST;
      acc_two_r <= ACC_RST;
    end else if (exec) begin
      if (sel_two) begin
        acc_two_r <= acc_nxt;
      end else begin
        acc_one_r <= acc_nxt;
      end
    end
  end

  // Guard flags are not sticky: the selected accumulator's flag is rewritten on each adder pass
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gov_one_r <= 1'b0;
      gov_two_r <= 1'b0;
    end else if (exec) begin
      if (sel_two) begin
        gov_two_r <= guard;
      end else begin
        gov_one_r <= guard;
      end
    end
  end

  // Sticky clamp and sign-lost flags, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clamp_one_r <= 1'b0;
      clamp_two_r <= 1'b0;
      lost_one_r  <= 1'b0;
      lost_two_r  <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_STAT) begin
        clamp_one_r <= clamp_one_r & ~pwdata[ST_CL1_BIT];
        clamp_two_r <= clamp_two_r & ~pwdata[ST_CL2_BIT];
        lost_one_r  <= lost_one_r & ~pwdata[ST_SL1_BIT];
        lost_two_r  <= lost_two_r & ~pwdata[ST_SL2_BIT];
      end
      if (exec && sat_hit && !sel_two) begin
        clamp_one_r <= 1'b1;
      end
      if (exec && sat_hit && sel_two) begin
        clamp_two_r <= 1'b1;
      end
      if (exec && ovf39 && !sel_two) begin
        lost_one_r <= 1'b1;
      end
      if (exec && ovf39 && sel_two) begin
        lost_two_r <= 1'b1;
      end
    end
  end

  // Trap pulse and its sticky flag; the flag's set beats a clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trap_r      <= 1'b0;
      trap_flag_r <= 1'b0;
    end else begin
      trap_r <= trap_hit;
      if (trap_hit) begin
        trap_flag_r <= 1'b1;
      end else if (wr_en && paddr == OFF_TRAP && pwdata[TRAP_FLAG_BIT]) begin
        trap_flag_r <= 1'b0;
      end
    end
  end

  // Status outputs
  assign arith_trap        = trap_r;
  assign acc_one_guard_ovf = gov_one_r;
  assign acc_two_guard_ovf = gov_two_r;
  assign acc_one_clamped   = clamp_one_r;
  assign acc_two_clamped   = clamp_two_r;
  assign any_guard_ovf     = gov_one_r | gov_two_r;
  assign any_clamped       = clamp_one_r | clamp_two_r;

endmodule : dspm_mac

// >>> test/dspm_mac_props.sv
// Checker of the datapath's flag and trap outputs, bound to the top module
`timescale 1ns/100ps
module dspm_mac_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        arith_trap,
  input wire logic        acc_one_guard_ovf,
  input wire logic        acc_two_guard_ovf,
  input wire logic        any_guard_ovf,
  input wire logic        acc_one_clamped,
  input wire logic        acc_two_clamped,
  input wire logic        any_clamped
);
  import dspm_pkg::*;
  logic wr_cmd;
  logic wr_stat;

  // Completed writes; results of a command land two edges after it is taken
  assign wr_cmd  = psel && penable && pwrite && (paddr == OFF_CMD);
  assign wr_stat = psel && penable && pwrite && (paddr == OFF_STAT);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_guard_or: assert property (any_guard_ovf == (acc_one_guard_ovf | acc_two_guard_ovf))
    else $error("summary guard flag is not the OR of both");
  chk_clamp_or: assert property (any_clamped == (acc_one_clamped | acc_two_clamped))
    else $error("summary clamp flag is not the OR of both");
  chk_trap_guard: assert property (arith_trap |-> any_guard_ovf)
    else $error("trap without guard overflow");
  chk_trap_cmd: assert property (arith_trap |-> $past(wr_cmd, 2))
    else $error("trap not two edges after a command");
  chk_trap_single: assert property (arith_trap |=> !arith_trap)
    else $error("trap longer than one cycle");
  chk_guard_cmd: assert property ($changed(acc_one_guard_ovf) || $changed(acc_two_guard_ovf)
    |-> $past(wr_cmd, 2))
    else $error("guard flag moved without an adder operation");
  chk_clamp_cmd: assert property ($rose(acc_one_clamped) || $rose(acc_two_clamped) |-> $past(wr_cmd, 2))
    else $error("clamp flag set without an operation");
  chk_clamp_one_hold: assert property (acc_one_clamped && !wr_stat |=> acc_one_clamped)
    else $error("first clamp flag dropped without a clear");
  chk_clamp_two_hold: assert property (acc_two_clamped && !wr_stat |=> acc_two_clamped)
    else $error("second clamp flag dropped without a clear");

  cov_trap: cover property (arith_trap);
  cov_clamp: cover property ($rose(any_clamped));
  cov_guard: cover property ($rose(any_guard_ovf));
endmodule : dspm_mac_props

bind dspm_mac dspm_mac_props u_props (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arith_trap(arith_trap), .acc_one_guard_ovf(acc_one_guard_ovf), .acc_two_guard_ovf(acc_two_guard_ovf),
  .any_guard_ovf(any_guard_ovf), .acc_one_clamped(acc_one_clamped), .acc_two_clamped(acc_two_clamped),
  .any_clamped(any_clamped));

// >>> test/dspm_core_model.sv
// Model of the core decoder side that issues register transfers
`timescale 1ns/100ps
module dspm_core_model (
  input  wire logic        clock,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic             err_seen
);
  initial begin
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    err_seen = 1'b0;
  end

  // One transfer; an idle cycle follows so a command lands before the next read
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q        = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
endmodule : dspm_core_model

// >>> test/dsp_multiply_accumulate_datapath_tb.sv
// Self-checking bench of the multiply-accumulate datapath
`timescale 1ns/100ps
module dsp_multiply_accumulate_datapath_tb;
  import dspm_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, err_seen, arith_trap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        g1, g2, ga, c1, c2, ca;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          traps = 0;
  logic [31:0] cores [4] = '{32'h0000_0006, 32'h0000_0000, 32'h0000_0002, 32'h0000_0004};
  logic [31:0] prods [4] = '{32'h0000_8000, 32'h7FFF_8000, 32'hFFFF_8000, 32'h8000_8000};

  always #10 clock = ~clock;

  dspm_core_model core (.clock(clock), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .err_seen(err_seen));
  dspm_mac dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .arith_trap(arith_trap),
    .acc_one_guard_ovf(g1), .acc_two_guard_ovf(g2), .any_guard_ovf(ga), .acc_one_clamped(c1),
    .acc_two_clamped(c2), .any_clamped(ca));

  // Trap pulses are counted here since they last a single cycle
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (arith_trap === 1'b1) begin
      traps <= traps + 1;
    end
    if (cycles == 5000) begin
      failures = failures + 1;
      results();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    core.xfer(1'b0, a, 32'h0000_0000, q);
    check(40'(q), 40'(exp));
  endtask : rdc

  // Flags f are {carry in, zero input, byte operands}; sh is the signed shift
  task automatic op(input logic [2:0] o, input logic sel, input logic [4:0] sh, input logic [2:0] f,
                    input logic [31:0] d);
    wr(OFF_DATA, d);
    wr(OFF_CMD, {19'h0_0000, sh, f, sel, 1'b0, o});
  endtask : op

  // Reads both words of an accumulator and joins them to forty bits
  task automatic racc(input logic sel, input logic [39:0] exp);
    logic [31:0] lo;
    core.xfer(1'b0, sel ? OFF_A2L : OFF_A1L, 32'h0000_0000, lo);
    core.xfer(1'b0, sel ? OFF_A2H : OFF_A1H, 32'h0000_0000, q);
    check({q[7:0], lo}, exp);
  endtask : racc

  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(OFF_CORE, 32'h0000_0007);
    // Fractional: -1 times -1, then a quarter, then subtract it back
    wr(OFF_OPA, 32'h0000_8000);
    wr(OFF_OPB, 32'h0000_8000);
    op(OP_MAC, 1'b0, 5'h00, 3'b000, 32'h0000_0000);
    racc(1'b0, 40'h00_8000_0000);
    wr(OFF_OPA, 32'h0000_4000);
    wr(OFF_OPB, 32'h0000_4000);
    op(OP_MAC, 1'b0, 5'h00, 3'b000, 32'h0000_0000);
    racc(1'b0, 40'h00_A000_0000);
    op(OP_MSC, 1'b0, 5'h00, 3'b100, 32'h0000_0000);
    racc(1'b0, 40'h00_8000_0000);
    $display("test fractional done");
    // Integer products in every signedness combination
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CORE, cores[i]);
      wr(OFF_OPA, 32'h0000_FFFF);
      wr(OFF_OPB, 32'h0000_8000);
      op(OP_PRODUCT, 1'b0, 5'h00, 3'b000, 32'h0000_0000);
      rdc(OFF_PROD, prods[i]);
    end
    // Byte operands, first unsigned and second signed: 255 times -1
    wr(OFF_OPA, 32'h0000_12FF);
    wr(OFF_OPB, 32'h0000_34FF);
    op(OP_PRODUCT, 1'b0, 5'h00, 3'b001, 32'h0000_0000);
    rdc(OFF_PROD, 32'h0000_FF01);
    $display("test products done");
    // Adder on the second accumulator; the first one must stay put
    op(OP_LOAD, 1'b1, 5'h00, 3'b000, 32'h0000_0005);
    op(OP_ADD, 1'b1, 5'h00, 3'b000, 32'h0000_0003);
    racc(1'b1, 40'h00_0000_0008);
    op(OP_SUB, 1'b1, 5'h00, 3'b100, 32'h0000_0003);
    racc(1'b1, 40'h00_0000_0005);
    op(OP_SUB, 1'b1, 5'h00, 3'b000, 32'h0000_0001);
    racc(1'b1, 40'h00_0000_0003);
    op(OP_ADD, 1'b1, 5'h00, 3'b010, 32'h0000_0007);
    racc(1'b1, 40'h00_0000_0007);
    op(OP_LOAD, 1'b1, 5'h02, 3'b000, 32'h0000_0010);
    racc(1'b1, 40'h00_0000_0004);
    racc(1'b0, 40'h00_8000_0000);
    $display("test adder done");
    // Guard overflow with the trap enabled, then a clean operation
    wr(OFF_TRAP, 32'h0000_0001);
    op(OP_LOAD, 1'b0, 5'h1E, 3'b000, 32'h4000_0000);
    racc(1'b0, 40'h01_0000_0000);
    check(40'(g1), 40'h1);
    check(40'(ga), 40'h1);
    check(40'(traps), 40'h1);
    rdc(OFF_TRAP, 32'h0000_0101);
    wr(OFF_TRAP, 32'h0000_0101);
    rdc(OFF_TRAP, 32'h0000_0001);
    op(OP_LOAD, 1'b0, 5'h00, 3'b000, 32'h0000_0001);
    racc(1'b0, 40'h00_0000_0001);
    check(40'(g1), 40'h0);
    $display("test guard done");
    // Clamp at 1.31 on the first accumulator, then clear its flag
    wr(OFF_CORE, 32'h0000_0080);
    op(OP_LOAD, 1'b0, 5'h1F, 3'b000, 32'h4000_0000);
    racc(1'b0, 40'h00_7FFF_FFFF);
    check(40'(c1), 40'h1);
    check(40'(ca), 40'h1);
    wr(OFF_STAT, 32'h0000_0008);
    check(40'(ca), 40'h0);
    // Overflow past the top bit, clamped at 9.31, trap not enabled
    wr(OFF_CORE, 32'h0000_0050);
    op(OP_LOAD, 1'b1, 5'h18, 3'b000, 32'h4000_0000);
    op(OP_ADD, 1'b1, 5'h18, 3'b000, 32'h4000_0000);
    racc(1'b1, 40'h7F_FFFF_FFFF);
    check(40'(c2), 40'h1);
    check(40'(g2), 40'h1);
    check(40'(traps), 40'h1);
    // Status word: second guard, both summaries, second clamp, second sign lost
    rdc(OFF_STAT, 32'h0000_00B6);
    $display("test saturation done");
    core.xfer(1'b0, 12'h030, 32'h0000_0000, q);
    check(40'(err_seen), 40'h1);
    check(40'(q), 40'h0);
    check(40'(pready), 40'h1);
    $display("test unmapped done");
    results();
  end
endmodule : dsp_multiply_accumulate_datapath_tb
